// [hdl/flash_seq_pkg.sv]
package flash_seq_pkg;
    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] clock_divider_off = 8'h00;
    localparam logic [7:0] option_off = 8'h04;
    localparam logic [7:0] status_off = 8'h08;
    localparam logic [7:0] command_off = 8'h0c;
    localparam logic [7:0] array_addr_off = 8'h10;
    localparam logic [7:0] array_data_off = 8'h14;
    localparam logic [7:0] key_lo_off = 8'h18;
    localparam logic [7:0] key_hi_off = 8'h1c;
    localparam logic [7:0] key_entry_lo_off = 8'h20;
    localparam logic [7:0] key_entry_hi_off = 8'h24;
    localparam logic [7:0] control_off = 8'h28;
    // nonvolatile store offsets, kept as array addresses
    localparam logic [15:0] fine_trim_store_off = 16'hffae;
    localparam logic [15:0] oscillator_trim_store_off = 16'hffaf;
    localparam logic [15:0] backdoor_comparison_key_off = 16'hffb0;
    localparam logic [15:0] protection_option_store_off = 16'hffbd;
    localparam logic [15:0] security_option_store_off = 16'hffbf;
    // ****************************************
    // field positions
    // ****************************************
    localparam int divider_loaded_pos = 7;
    localparam int prescale_by8_pos = 6;
    localparam int cbe_pos = 7;
    localparam int ccf_pos = 6;
    localparam int accerr_pos = 4;
    localparam int blank_pos = 2;
    localparam int key_enable_pos = 7;
    localparam int unsecure_pos = 0;
    localparam int bdm_pos = 0;
    localparam logic [1:0] unsecured_pattern = 2'h2;
    // ****************************************
    // commands
    // ****************************************
    localparam logic [7:0] cmd_blank_check = 8'h05;
    localparam logic [7:0] cmd_byte_program = 8'h20;
    localparam logic [7:0] cmd_burst_program = 8'h25;
    localparam logic [7:0] cmd_page_erase = 8'h40;
    localparam logic [7:0] cmd_mass_erase = 8'h41;
    // ****************************************
    // timing in flash timing clock cycles
    // ****************************************
    localparam logic [15:0] cycles_byte_program = 16'h0009;
    localparam logic [15:0] cycles_burst_program = 16'h0004;
    localparam logic [15:0] cycles_page_erase = 16'h0fa0;
    localparam logic [15:0] cycles_mass_erase = 16'h4e20;
    localparam logic [15:0] cycles_blank_check = 16'h0001;
    localparam int page_bytes = 512;
    localparam int ftclk_min_khz = 150;
    localparam int ftclk_max_khz = 200;
    localparam logic [7:0] security_option_reset = 8'hff;
    localparam logic [63:0] key_reset = 64'hffffffffffffffff;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_addr = 2'b01,
        st_cmd = 2'b10,
        st_busy = 2'b11
    } seq_state_t;
endpackage

// [hdl/tick_divider.sv]
`timescale 1ns/1ps
module tick_divider #(
    parameter int WIDTH = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic by8,
    input wire logic [WIDTH-1:0] div,
    output logic tick
);
    // ****************************************
    // period = (div+1) * (by8 ? 8 : 1) clocks
    // ****************************************
    initial begin
        if (WIDTH < 1 || WIDTH > 16) begin
            $error("tick_divider width out of range");
        end
    end
    logic [WIDTH-1:0] cnt_q;
    logic [2:0] pre_q;
    wire pre_wrap = !by8 || (pre_q == 3'h7);
    wire cnt_wrap = pre_wrap && (cnt_q == div);
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            cnt_q <= '0;
            pre_q <= 3'h0;
            tick <= 1'b0;
        end else begin
            pre_q <= pre_wrap ? 3'h0 : pre_q + 3'h1;
            if (pre_wrap) begin
                cnt_q <= cnt_wrap ? '0 : cnt_q + 1'b1;
            end
            tick <= cnt_wrap;
        end
    end
endmodule

// [hdl/flash_command_sequencer.sv]
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// R01: host sets timing clock 150 to 200 kHz
// R02: divider register accepts one write only
// R03: divider writes ignored while access error
// R04: pulses counted in whole timing clock ticks
// R05: byte program 9, burst 4 ticks
// R06: page erase 4000, mass erase 20000 ticks
// R07: first step latches array address, data
// R08: mass erase, blank check accept any address
// R09: second step latches command code
// R10: page erase 0x40, mass erase 0x41
// R11: writing one to empty bit launches command
// R12: writing zero before launch aborts, errors
// R13: access error blocks new commands
// R14: complete flag marks command finished
// R15: erase unit is one 512-byte page
// R16: host never reprograms byte without erase
// R17: array 4096 bytes, eight pages default
// R18: matching key disengages security when enabled
// R19: key entry refused from background debug
// R20: key disabled: mass erase plus blank
// R21: pattern 1:0 unsecures after next reset
// R22: unknown command code sets access error
// R23: array write while busy sets error
// R24: access error cleared by writing one
// R25: complete drops on launch, rises after count
module flash_command_sequencer #(
    parameter int ARRAY_BYTES = 4096,
    parameter int DIV_WIDTH = 6,
    parameter int FTCLK_KHZ_NOM = 200
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] security_option_store,
    input wire logic [63:0] backdoor_comparison_key,
    output logic array_program_pulse,
    output logic array_erase_pulse,
    output logic [15:0] array_target_addr,
    output logic [7:0] array_target_data,
    input wire logic array_is_blank,
    output logic secured
);
    // ****************************************
    // elaboration checks
    // ****************************************
    localparam int ADDR_W = $clog2(ARRAY_BYTES);
    localparam int PAGE_W = $clog2(flash_seq_pkg::page_bytes);
    initial begin
        if (ARRAY_BYTES != 4096 && ARRAY_BYTES != 2048) begin // R17
            $error("array size must be 4096 or 2048");
        end
        if (DIV_WIDTH < 1 || DIV_WIDTH > 6) begin
            $error("divider width out of range");
        end
    end
    // ****************************************
    // write channel capture
    // ****************************************
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    wire wr_go = aw_have_q && w_have_q;
    wire wr_lane0 = wr_go && w_strb_q[0];
    wire [7:0] wbyte = w_data_q[7:0];
    wire wr_div = wr_lane0 && (aw_addr_q == flash_seq_pkg::clock_divider_off);
    wire wr_stat = wr_lane0 && (aw_addr_q == flash_seq_pkg::status_off);
    wire wr_cmd = wr_lane0 && (aw_addr_q == flash_seq_pkg::command_off);
    wire wr_aaddr = wr_go && (aw_addr_q == flash_seq_pkg::array_addr_off);
    wire wr_adata = wr_lane0 && (aw_addr_q == flash_seq_pkg::array_data_off);
    wire wr_klo = wr_go && (aw_addr_q == flash_seq_pkg::key_entry_lo_off);
    wire wr_khi = wr_go && (aw_addr_q == flash_seq_pkg::key_entry_hi_off);
    wire wr_ctl = wr_lane0 && (aw_addr_q == flash_seq_pkg::control_off);
    wire wr_known = wr_div || wr_stat || wr_cmd || wr_aaddr || wr_adata || wr_klo
        || wr_khi || wr_ctl;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_known || !w_strb_q[0]) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // ****************************************
    // option and security state
    // ****************************************
    logic boot_q, unsecure_q, key_ok_q, bdm_q;
    logic [7:0] opt_q;
    logic [63:0] key_entry_q;
    wire key_enable = opt_q[flash_seq_pkg::key_enable_pos];
    assign secured = !unsecure_q;
    // ****************************************
    // divider and timing clock
    // ****************************************
    logic [7:0] div_q;
    logic tick;
    wire div_loaded = div_q[flash_seq_pkg::divider_loaded_pos];
    logic accerr_q, cbe_q, ccf_q, blank_q;
    tick_divider #(
        .WIDTH(DIV_WIDTH)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(div_loaded),
        .by8(div_q[flash_seq_pkg::prescale_by8_pos]),
        .div(div_q[DIV_WIDTH-1:0]),
        .tick(tick)
    );
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 8'h00;
        end else if (wr_div && !div_loaded && !accerr_q) begin // R02 R03
            div_q <= {1'b1, wbyte[6:0]};
        end
    end
    // ****************************************
    // command sequencer
    // ****************************************
    flash_seq_pkg::seq_state_t state_q;
    logic [7:0] cmd_q;
    logic [15:0] addr_q;
    logic [7:0] data_q;
    logic [15:0] left_q;
    wire cmd_valid = (wbyte == flash_seq_pkg::cmd_blank_check)
        || (wbyte == flash_seq_pkg::cmd_byte_program)
        || (wbyte == flash_seq_pkg::cmd_burst_program)
        || (wbyte == flash_seq_pkg::cmd_page_erase)
        || (wbyte == flash_seq_pkg::cmd_mass_erase); // R09 R10 R22
    wire cmd_bdm_bad = bdm_q && secured && (wbyte != flash_seq_pkg::cmd_blank_check)
        && (wbyte != flash_seq_pkg::cmd_mass_erase);
    wire launch = wr_stat && wbyte[flash_seq_pkg::cbe_pos] && (state_q == flash_seq_pkg::st_cmd);
    wire abort = wr_stat && !wbyte[flash_seq_pkg::cbe_pos]
        && (state_q != flash_seq_pkg::st_idle) && (state_q != flash_seq_pkg::st_busy); // R12
    wire arr_write_bad = wr_adata && (!cbe_q || !div_loaded
        || (state_q != flash_seq_pkg::st_idle)); // R23
    wire ctrl_after_addr = wr_div && (state_q == flash_seq_pkg::st_addr);
    wire cmd_bad = wr_cmd && (state_q != flash_seq_pkg::st_addr || !cmd_valid || cmd_bdm_bad);
    wire err_set = arr_write_bad || abort || cmd_bad || ctrl_after_addr;
    wire err_clr = wr_stat && wbyte[flash_seq_pkg::accerr_pos]; // R24
    wire is_erase = (cmd_q == flash_seq_pkg::cmd_page_erase)
        || (cmd_q == flash_seq_pkg::cmd_mass_erase);
    wire [15:0] run_cycles = (cmd_q == flash_seq_pkg::cmd_byte_program)
        ? flash_seq_pkg::cycles_byte_program // R05
        : (cmd_q == flash_seq_pkg::cmd_burst_program) ? flash_seq_pkg::cycles_burst_program
        : (cmd_q == flash_seq_pkg::cmd_page_erase) ? flash_seq_pkg::cycles_page_erase // R06
        : (cmd_q == flash_seq_pkg::cmd_mass_erase) ? flash_seq_pkg::cycles_mass_erase
        : flash_seq_pkg::cycles_blank_check;
    wire [15:0] page_mask = 16'hffff << PAGE_W;
    wire [15:0] arr_mask = 16'(ARRAY_BYTES - 1);
    wire mass_like = (cmd_q == flash_seq_pkg::cmd_mass_erase)
        || (cmd_q == flash_seq_pkg::cmd_blank_check);
    wire [15:0] target = mass_like ? 16'h0000 // R08
        : (cmd_q == flash_seq_pkg::cmd_page_erase) ? (addr_q & arr_mask & page_mask) // R15
        : (addr_q & arr_mask);
    wire done = (state_q == flash_seq_pkg::st_busy) && tick && (left_q == 16'h0001);
    wire blank_done = done && (cmd_q == flash_seq_pkg::cmd_blank_check);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= flash_seq_pkg::st_idle;
            cmd_q <= 8'h00;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
            left_q <= 16'h0000;
        end else begin
            if (wr_aaddr && state_q == flash_seq_pkg::st_idle) begin
                addr_q <= w_data_q[15:0];
            end
            case (state_q)
                flash_seq_pkg::st_idle: begin
                    if (wr_adata && !arr_write_bad && !accerr_q) begin // R07 R13
                        data_q <= wbyte;
                        state_q <= flash_seq_pkg::st_addr;
                    end
                end
                flash_seq_pkg::st_addr: begin
                    if (abort || ctrl_after_addr || cmd_bad || wr_adata) begin
                        state_q <= flash_seq_pkg::st_idle;
                    end else if (wr_cmd) begin
                        cmd_q <= wbyte; // R09
                        state_q <= flash_seq_pkg::st_cmd;
                    end
                end
                flash_seq_pkg::st_cmd: begin
                    if (abort || wr_cmd || wr_adata || wr_div) begin
                        state_q <= flash_seq_pkg::st_idle;
                    end else if (launch) begin // R11
                        left_q <= run_cycles;
                        state_q <= flash_seq_pkg::st_busy;
                    end
                end
                flash_seq_pkg::st_busy: begin
                    if (tick) begin // R04
                        left_q <= left_q - 16'h0001;
                        if (left_q == 16'h0001) begin
                            state_q <= flash_seq_pkg::st_idle;
                        end
                    end
                end
                default: begin
                    state_q <= flash_seq_pkg::st_idle;
                end
            endcase
        end
    end
    // ****************************************
    // status flags
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accerr_q <= 1'b0;
            cbe_q <= 1'b1;
            ccf_q <= 1'b1;
            blank_q <= 1'b0;
        end else begin
            if (err_set) begin
                accerr_q <= 1'b1;
            end else if (err_clr) begin
                accerr_q <= 1'b0;
            end
            if (launch) begin
                cbe_q <= 1'b0;
                ccf_q <= 1'b0; // R25
                blank_q <= 1'b0;
            end else if (done) begin
                cbe_q <= 1'b1;
                ccf_q <= 1'b1; // R14 R25
            end
            if (blank_done) begin
                blank_q <= array_is_blank;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            array_program_pulse <= 1'b0;
            array_erase_pulse <= 1'b0;
            array_target_addr <= 16'h0000;
            array_target_data <= 8'h00;
        end else begin
            array_program_pulse <= (state_q == flash_seq_pkg::st_busy) && tick && !is_erase
                && (cmd_q != flash_seq_pkg::cmd_blank_check);
            array_erase_pulse <= (state_q == flash_seq_pkg::st_busy) && tick && is_erase;
            array_target_addr <= target;
            array_target_data <= data_q;
        end
    end
    // ****************************************
    // security
    // ****************************************
    wire key_match = key_enable && !bdm_q && (key_entry_q == backdoor_comparison_key); // R18 R19
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_q <= 1'b1;
            opt_q <= flash_seq_pkg::security_option_reset;
            unsecure_q <= 1'b0;
            key_ok_q <= 1'b0;
            key_entry_q <= flash_seq_pkg::key_reset;
            bdm_q <= 1'b0;
        end else begin
            boot_q <= 1'b0;
            if (boot_q) begin
                opt_q <= security_option_store;
                unsecure_q <= (security_option_store[1:0] == flash_seq_pkg::unsecured_pattern); // R21
            end else if (key_ok_q && key_match) begin
                unsecure_q <= 1'b1;
            end else if (blank_done && array_is_blank && !key_enable) begin // R20
                unsecure_q <= 1'b1;
            end
            if (wr_ctl) begin
                bdm_q <= wbyte[flash_seq_pkg::bdm_pos];
            end
            if (wr_klo && !bdm_q) begin // R19
                key_entry_q[31:0] <= w_data_q;
            end
            if (wr_khi && !bdm_q) begin
                key_entry_q[63:32] <= w_data_q;
            end
            key_ok_q <= wr_khi && !bdm_q;
        end
    end
    // ****************************************
    // read channel
    // ****************************************
    wire [7:0] stat_byte = {cbe_q, ccf_q, 1'b0, accerr_q, 1'b0, blank_q, 2'b00};
    wire [7:0] ra = s_axi_araddr;
    wire rd_known = ra == flash_seq_pkg::clock_divider_off || ra == flash_seq_pkg::option_off
        || ra == flash_seq_pkg::status_off || ra == flash_seq_pkg::command_off
        || ra == flash_seq_pkg::array_addr_off || ra == flash_seq_pkg::array_data_off
        || ra == flash_seq_pkg::control_off || ra == flash_seq_pkg::key_lo_off
        || ra == flash_seq_pkg::key_hi_off;
    wire [31:0] rd_word = (ra == flash_seq_pkg::clock_divider_off) ? {24'h0, div_q}
        : (ra == flash_seq_pkg::option_off) ? {24'h0, opt_q[7:2], ~unsecure_q, unsecure_q}
        : (ra == flash_seq_pkg::status_off) ? {24'h0, stat_byte}
        : (ra == flash_seq_pkg::command_off) ? {24'h0, cmd_q}
        : (ra == flash_seq_pkg::array_addr_off) ? {16'h0, addr_q}
        : (ra == flash_seq_pkg::array_data_off) ? {24'h0, data_q}
        : (ra == flash_seq_pkg::control_off) ? {31'h0, bdm_q}
        : 32'h00000000;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [dv/flash_seq_chk.sv]
`timescale 1ns/1ps
module flash_seq_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic array_program_pulse,
    input wire logic array_erase_pulse,
    input wire logic [15:0] array_target_addr,
    input wire logic [7:0] array_target_data,
    input wire logic secured
);
    // ****
    // run counters
    // ****
    logic [15:0] prun_q, erun_q;
    wire logic ar_hs = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        prun_q <= (!aresetn || !array_program_pulse) ? 16'h0 : prun_q + 16'h1;
        erun_q <= (!aresetn || !array_erase_pulse) ? 16'h0 : erun_q + 16'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    pulse_excl_a: assert property (!(array_program_pulse && array_erase_pulse))
        else $error("pulses overlap");
    prog_run_a: assert property (prun_q <= 16'h9)
        else $error("program run long");
    erase_run_a: assert property (erun_q <= 16'h4e20)
        else $error("erase run long");
    erase_page_a: assert property (array_erase_pulse |-> array_target_addr[8:0] == 9'h000)
        else $error("erase unaligned");
    pulse_stable_a: assert property (array_program_pulse && $past(array_program_pulse)
        |-> $stable(array_target_addr) && $stable(array_target_data))
        else $error("target moved");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken in response");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read response late");
    bad_read_a: assert property (ar_hs && s_axi_araddr > 8'h28 |=> s_axi_rresp == 2'h2)
        else $error("bad read accepted");
    reset_secure_a: assert property (disable iff (1'b0) !aresetn |=> secured)
        else $error("not secured in reset");
    cover property (erun_q == 16'h4e20);
    cover property (prun_q == 16'h0009);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind flash_command_sequencer flash_seq_chk chk (.*);

// [dv/flash_array_model.sv]
`timescale 1ns/1ps
module flash_array_model (
    input wire logic aclk,
    input wire logic program_pulse,
    input wire logic erase_pulse,
    output logic is_blank,
    output int prog_cnt,
    output int erase_cnt
);
    // ****
    // pulse count
    // ****
    initial begin
        is_blank = 1'b0;
    end
    always @(posedge aclk) begin
        if (program_pulse) begin
            prog_cnt <= prog_cnt + 1;
            is_blank <= 1'b0;
        end
        if (erase_pulse) begin
            erase_cnt <= erase_cnt + 1;
            is_blank <= 1'b1;
        end
    end
endmodule

// [dv/flash_command_sequencer_test.sv]
`timescale 1ns/1ps
module flash_command_sequencer_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, security_option_store = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [63:0] backdoor_comparison_key = 64'h0, key;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic array_program_pulse, array_erase_pulse, array_is_blank, secured;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] array_target_addr, ad;
    logic [7:0] array_target_data, dt;
    logic [7:0] bad[3] = '{8'h04, 8'h21, 8'h42};
    int fail_count = 0, compares = 0, cyc = 0, pc, ec, p0, e0;
    always #12.5 aclk = ~aclk;
    flash_command_sequencer DUT (.*);
    flash_array_model far (.aclk(aclk), .program_pulse(array_program_pulse),
        .erase_pulse(array_erase_pulse), .is_blank(array_is_blank), .prog_cnt(pc), .erase_cnt(ec));
    // ****
    // bus and check tasks
    // ****
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b_t = 1'b0;
        while (b_t !== 1'b1) begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
    endtask
    task rd(input logic [7:0] a);
        logic ar_t, r_t;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        r_t = 1'b0;
        while (r_t !== 1'b1) begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            rv = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end
    endtask
    task st();
        rd(flash_seq_pkg::status_off);
    endtask
    task clr();
        wr(flash_seq_pkg::status_off, 32'h10);
        st();
        chk("cleared", rv[4], 32'h0);
    endtask
    task rst(input logic [7:0] opt);
        aresetn <= 1'b0;
        security_option_store <= opt;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask
    task key_in(input logic [31:0] ctl);
        wr(flash_seq_pkg::control_off, ctl);
        wr(flash_seq_pkg::key_entry_lo_off, key[31:0]);
        wr(flash_seq_pkg::key_entry_hi_off, key[63:32]);
        @(negedge aclk);
    endtask
    task launch(input logic [7:0] c, input logic [15:0] a);
        dt = 8'($urandom);
        wr(flash_seq_pkg::array_addr_off, {16'h0, a});
        wr(flash_seq_pkg::array_data_off, {24'h0, dt});
        wr(flash_seq_pkg::command_off, {24'h0, c});
        wr(flash_seq_pkg::status_off, 32'h80);
    endtask
    task wait_done();
        do st(); while (rv[6] !== 1'b1);
    endtask
    task run(input logic [7:0] c, input logic [15:0] a, input int np, input int ne,
        input logic [15:0] ea);
        p0 = pc;
        e0 = ec;
        launch(c, a);
        st();
        if (np + ne > 8) chk("early", rv[6], 32'h0);
        wait_done();
        chk("programs", pc - p0, np);
        chk("erases", ec - e0, ne);
        chk("addr", array_target_addr, ea);
        if (np > 0) chk("data", array_target_data, dt);
    endtask
    task test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            test_done();
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        rv = $urandom(32'h7e92);
        key = {$urandom, $urandom};
        backdoor_comparison_key <= key;
        rst(8'h00);
        chk("secured", secured, 32'h1);
        st();
        chk("status", rv & 32'hd0, 32'hc0);
        wr(flash_seq_pkg::array_data_off, 32'h0);
        wr(flash_seq_pkg::clock_divider_off, 32'h0);
        rd(flash_seq_pkg::clock_divider_off);
        chk("loaded", rv[7], 32'h0);
        clr();
        wr(flash_seq_pkg::clock_divider_off, 32'h0);
        wr(flash_seq_pkg::clock_divider_off, 32'h3f);
        rd(flash_seq_pkg::clock_divider_off);
        chk("divider", rv[7:0], 32'h80);
        $display("test divider done");
        ad = 16'($urandom) & 16'h0ffe;
        foreach (bad[i]) begin
            launch(bad[i], ad);
            st();
            chk("bad code", rv[4], 32'h1);
            clr();
        end
        wr(flash_seq_pkg::array_data_off, 32'h0);
        wr(flash_seq_pkg::status_off, 32'h0);
        st();
        chk("abort", rv[4], 32'h1);
        p0 = pc;
        launch(flash_seq_pkg::cmd_byte_program, ad);
        repeat (20) @(posedge aclk);
        chk("refused", pc - p0, 32'h0);
        clr();
        key_in(32'h0);
        chk("secured", secured, 32'h1);
        run(flash_seq_pkg::cmd_page_erase, ad, 0, 4000, ad & 16'hfe00);
        run(flash_seq_pkg::cmd_byte_program, ad, 9, 0, ad);
        run(flash_seq_pkg::cmd_burst_program, ad + 16'h1, 4, 0, ad + 16'h1);
        run(flash_seq_pkg::cmd_blank_check, ad, 0, 0, 16'h0);
        chk("blank", rv[2], 32'h0);
        launch(flash_seq_pkg::cmd_page_erase, ad);
        wr(flash_seq_pkg::array_data_off, 32'h0);
        st();
        chk("busy", rv[4], 32'h1);
        wait_done();
        clr();
        run(flash_seq_pkg::cmd_mass_erase, ad, 0, 20000, 16'h0);
        run(flash_seq_pkg::cmd_blank_check, ~ad, 0, 0, 16'h0);
        chk("blank", rv[2], 32'h1);
        chk("secured", secured, 32'h0);
        $display("test commands done");
        rst(8'h80);
        key_in(32'h1);
        chk("secured", secured, 32'h1);
        key_in(32'h0);
        chk("secured", secured, 32'h0);
        rst(8'h02);
        chk("secured", secured, 32'h0);
        wr(8'h40, 32'h0);
        chk("bresp", resp, 32'h2);
        rd(8'h40);
        chk("rresp", resp, 32'h2);
        $display("test security done");
        test_done();
    end
endmodule
